/* common/cl_pixel_regs.svh */
// Timing counts and fixed values for the pixel output formatter
`ifndef CL_PIXEL_REGS_SVH
`define CL_PIXEL_REGS_SVH
// Line lead-in (LVAL before DVAL), single and dual tap, per binning
`define CL_HLEAD_S_B1 11'h066
`define CL_HLEAD_S_B2 11'h047
`define CL_HLEAD_S_B4 11'h038
`define CL_HLEAD_S_B8 11'h030
`define CL_HLEAD_D_B1 11'h054
`define CL_HLEAD_D_B2 11'h03E
`define CL_HLEAD_D_B4 11'h033
`define CL_HLEAD_D_B8 11'h02E
// Active pixel clocks per line (DVAL high)
`define CL_HACT_S_B1 11'h280
`define CL_HACT_S_B2 11'h140
`define CL_HACT_S_B4 11'h0A0
`define CL_HACT_S_B8 11'h050
`define CL_HACT_D_B1 11'h140
`define CL_HACT_D_B2 11'h0A0
`define CL_HACT_D_B4 11'h050
`define CL_HACT_D_B8 11'h028
// Lead line periods inside FVAL, per binning
`define CL_VLEAD_B1 9'h00D
`define CL_VLEAD_B2 9'h007
`define CL_VLEAD_B4 9'h004
`define CL_VLEAD_B8 9'h003
// Active lines per frame, per binning
`define CL_VACT_B1 9'h1E0
`define CL_VACT_B2 9'h0F0
`define CL_VACT_B4 9'h078
`define CL_VACT_B8 9'h03C
// Horizontal and vertical blanking in link clocks
`define CL_HBLANK 11'h010
`define CL_VBLANK 11'h040
// Unity contrast gain in Q8
`define CL_GAIN_UNITY 12'h100
`endif

/* common/cl_pixel_pkg.sv */
// Types shared by the pixel output formatter
package cl_pixel_pkg;
    // One converter word, bit 0 is the LSB
    typedef logic [11:0] pixel_word_bits_t;
    // Pixels of both taps for one link clock
    typedef struct packed {
        pixel_word_bits_t tap_b;
        pixel_word_bits_t tap_a;
    } pixel_pair_t;
    // Readout binning
    typedef enum logic [1:0] {BIN_NONE, BIN_2X2, BIN_4X4, BIN_8X8} bin_mode_t;
    // Timing generator states
    typedef enum logic [2:0] {L_IDLE, L_LEAD, L_HLEAD, L_ACT, L_HBLK, L_VBLK} link_state_t;
endpackage : cl_pixel_pkg

/* core/pixel_fifo.sv */
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Write side
    input wire logic wr_clk,
    input wire logic wr_rst_n,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    // Read side
    input wire logic rd_clk,
    input wire logic rd_rst_n,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage, written on wr_clk only
    logic [AW:0] wbin_r, wgray_r, wbin_nxt, wgray_nxt;
    logic [AW:0] rbin_r, rgray_r, rbin_nxt, rgray_nxt;
    logic [AW:0] rg_s1_r, rg_s2_r; // Read pointer seen by writer
    logic [AW:0] wg_s1_r, wg_s2_r; // Write pointer seen by reader
    logic push, pop;

    assign push = wr_valid & wr_ready;
    assign pop = rd_valid & rd_ready;
    assign wbin_nxt = wbin_r + {{AW{1'h0}}, push};
    assign wgray_nxt = wbin_nxt ^ (wbin_nxt >> 1);
    assign rbin_nxt = rbin_r + {{AW{1'h0}}, pop};
    assign rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
    // Read is combinational; a slot is written before its pointer crosses
    assign rd_data = mem[rbin_r[AW-1:0]];

    // Storage write
    always_ff @(posedge wr_clk) begin
        if (push) begin
            mem[wbin_r[AW-1:0]] <= wr_data;
        end
    end

    // Write pointer and registered full flag
    always_ff @(posedge wr_clk or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wbin_r <= '0;
            wgray_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
            wr_ready <= 1'h0;
        end else begin
            wbin_r <= wbin_nxt;
            wgray_r <= wgray_nxt;
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
            // Full when top two gray bits differ and the rest match
            wr_ready <= (wgray_nxt != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
        end
    end

    // Read pointer and registered empty flag
    always_ff @(posedge rd_clk or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rbin_r <= '0;
            rgray_r <= '0;
            wg_s1_r <= '0;
            wg_s2_r <= '0;
            rd_valid <= 1'h0;
        end else begin
            rbin_r <= rbin_nxt;
            rgray_r <= rgray_nxt;
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
            rd_valid <= (rgray_nxt != wg_s2_r);
        end
    end
endmodule : pixel_fifo

/* core/camera_link_pixel_output.sv */
// Pixel output formatter driving the 28 serializer inputs of a base link port
//
// Overview of operation
// - Drive 28 parallel serializer input bits
// - Base link port, 12-bit pixel words
// - First-tap bits mapped onto their lanes
// - Second-tap bits mapped; lane 23 spare
// - DVAL on lane 26 marks valid pixels
// - LVAL on lane 24 during active lines
// - FVAL on lane 25 during active frame
// - Pixel bit 0 least significant
// - External trigger with selectable polarity
// - Normal readout gives 640 by 480
// - Contrast gain, 16 steps, 0-14 dB
// - Optional control line carries trigger
// - Line lead-in then active pixel clocks
// - Lead lines then active lines per frame
`timescale 1ns/1ps
`include "cl_pixel_regs.svh"
module camera_link_pixel_output (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Link pixel clock
    input wire logic link_clk,
    // Pixel source, core domain
    input wire cl_pixel_pkg::pixel_pair_t pix_in,
    input wire logic pix_valid,
    output logic pix_ready,
    // Configuration levels, core domain
    input wire logic dual_tap,
    input wire cl_pixel_pkg::bin_mode_t bin_mode,
    input wire logic [3:0] gain_step,
    input wire logic ext_mode,
    input wire logic trig_pol_pos,
    input wire logic trig_src_cc,
    // Trigger pins
    input wire logic trig_pin,
    input wire logic cc1_pin,
    // Serializer inputs
    output logic [27:0] tx
);
    // Q8 contrast gain, about 0.93 dB per step
    function automatic logic [11:0] gain_q8_f(input logic [3:0] s);
        case (s)
            4'h0: return 12'h100;
            4'h1: return 12'h11D;
            4'h2: return 12'h13D;
            4'h3: return 12'h161;
            4'h4: return 12'h189;
            4'h5: return 12'h1B6;
            4'h6: return 12'h1E8;
            4'h7: return 12'h21F;
            4'h8: return 12'h25D;
            4'h9: return 12'h2A1;
            4'hA: return 12'h2EE;
            4'hB: return 12'h343;
            4'hC: return 12'h3A2;
            4'hD: return 12'h40B;
            4'hE: return 12'h480;
            default: return 12'h503;
        endcase
    endfunction : gain_q8_f

    // Gain applied to one word, saturating at full scale
    function automatic cl_pixel_pkg::pixel_word_bits_t gain_f(
        input cl_pixel_pkg::pixel_word_bits_t p, input logic [3:0] s);
        logic [23:0] prod;
        prod = p * gain_q8_f(s);
        return (|prod[23:20]) ? 12'hFFF : prod[19:8];
    endfunction : gain_f

    // Line lead-in per tap count and binning
    function automatic logic [10:0] h_lead_f(input logic d, input cl_pixel_pkg::bin_mode_t b);
        case (b)
            cl_pixel_pkg::BIN_NONE: return d ? `CL_HLEAD_D_B1 : `CL_HLEAD_S_B1;
            cl_pixel_pkg::BIN_2X2: return d ? `CL_HLEAD_D_B2 : `CL_HLEAD_S_B2;
            cl_pixel_pkg::BIN_4X4: return d ? `CL_HLEAD_D_B4 : `CL_HLEAD_S_B4;
            default: return d ? `CL_HLEAD_D_B8 : `CL_HLEAD_S_B8;
        endcase
    endfunction : h_lead_f

    // Active clocks per line per tap count and binning
    function automatic logic [10:0] h_act_f(input logic d, input cl_pixel_pkg::bin_mode_t b);
        case (b)
            cl_pixel_pkg::BIN_NONE: return d ? `CL_HACT_D_B1 : `CL_HACT_S_B1;
            cl_pixel_pkg::BIN_2X2: return d ? `CL_HACT_D_B2 : `CL_HACT_S_B2;
            cl_pixel_pkg::BIN_4X4: return d ? `CL_HACT_D_B4 : `CL_HACT_S_B4;
            default: return d ? `CL_HACT_D_B8 : `CL_HACT_S_B8;
        endcase
    endfunction : h_act_f

    // Lead and active line counts per binning, packed {lead, active}
    function automatic logic [17:0] v_cnt_f(input cl_pixel_pkg::bin_mode_t b);
        case (b)
            cl_pixel_pkg::BIN_NONE: return {`CL_VLEAD_B1, `CL_VACT_B1};
            cl_pixel_pkg::BIN_2X2: return {`CL_VLEAD_B2, `CL_VACT_B2};
            cl_pixel_pkg::BIN_4X4: return {`CL_VLEAD_B4, `CL_VACT_B4};
            default: return {`CL_VLEAD_B8, `CL_VACT_B8};
        endcase
    endfunction : v_cnt_f

    // Lane mapping of both taps and the three qualifiers
    function automatic logic [27:0] tx_map_f(input cl_pixel_pkg::pixel_pair_t p,
        input logic lv, input logic fv, input logic dv);
        logic [27:0] t;
        t = 28'h0000000;
        t[4:0] = p.tap_a[4:0];
        t[6] = p.tap_a[5];
        t[27] = p.tap_a[6];
        t[5] = p.tap_a[7];
        t[9:7] = p.tap_a[10:8];
        t[12] = p.tap_a[11];
        t[15] = p.tap_b[0];
        t[22:18] = p.tap_b[5:1];
        t[16] = p.tap_b[6];
        t[17] = p.tap_b[7];
        t[14:13] = p.tap_b[9:8];
        t[11:10] = p.tap_b[11:10];
        t[23] = 1'h0;
        t[24] = lv;
        t[25] = fv;
        t[26] = dv;
        return t;
    endfunction : tx_map_f

    // Reset synchronisers, one per domain
    logic crst_s1_r, crst_n_r, lrst_s1_r, lrst_n_r;
    // Core-domain pixel stage
    cl_pixel_pkg::pixel_pair_t stage_r;
    logic stage_vld_r, stage_vld_nxt, accept, fifo_wready;
    // Trigger path
    logic [1:0] pin_s1_r, pin_s2_r; // {cc1, trigger} synchronisers
    logic trig_act, trig_prev_r, trig_tgl_r;
    // Link-domain side
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r, trig_edge, trig_pend_r, start;
    logic [3:0] cfg_s1_r, cfg_s2_r; // {ext, bin, dual} synchronisers
    cl_pixel_pkg::link_state_t state_r;
    cl_pixel_pkg::pixel_pair_t fifo_rd;
    cl_pixel_pkg::bin_mode_t frm_bin_r;
    logic fifo_rvalid, pop, frm_dual_r;
    logic [10:0] pix_cnt_r, h_lead_r, h_act_r, line_len;
    logic [8:0] line_cnt_r, v_lead_r, v_act_r;
    logic lval_nxt, fval_nxt;

    // Core reset release through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            crst_s1_r <= 1'h0;
            crst_n_r <= 1'h0;
        end else begin
            crst_s1_r <= 1'h1;
            crst_n_r <= crst_s1_r;
        end
    end

    // Link reset release through two flops
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            lrst_s1_r <= 1'h0;
            lrst_n_r <= 1'h0;
        end else begin
            lrst_s1_r <= 1'h1;
            lrst_n_r <= lrst_s1_r;
        end
    end

    // One-entry gain stage; ready is registered, so it runs at half rate
    assign accept = pix_valid & pix_ready;
    assign stage_vld_nxt = accept | (stage_vld_r & ~fifo_wready);
    always_ff @(posedge core_clk or negedge crst_n_r) begin
        if (!crst_n_r) begin
            stage_r <= '0;
            stage_vld_r <= 1'h0;
            pix_ready <= 1'h0;
        end else begin
            if (accept) begin
                stage_r.tap_a <= gain_f(pix_in.tap_a, gain_step);
                // Second tap zeroed in single-tap readout
                stage_r.tap_b <= dual_tap ? gain_f(pix_in.tap_b, gain_step) : 12'h000;
            end
            stage_vld_r <= stage_vld_nxt;
            pix_ready <= ~stage_vld_nxt;
        end
    end

    // Trigger pins synchronised before use
    always_ff @(posedge core_clk or negedge crst_n_r) begin
        if (!crst_n_r) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
        end else begin
            pin_s1_r <= {cc1_pin, trig_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Source select and polarity; a positive trigger is active high
    assign trig_act = (trig_src_cc ? pin_s2_r[1] : pin_s2_r[0]) ^ ~trig_pol_pos;

    // Active edge becomes a toggle so it crosses as an event
    always_ff @(posedge core_clk or negedge crst_n_r) begin
        if (!crst_n_r) begin
            trig_prev_r <= 1'h1; // Active level straight after reset is no edge
            trig_tgl_r <= 1'h0;
        end else begin
            trig_prev_r <= trig_act;
            if (trig_act & ~trig_prev_r) begin
                trig_tgl_r <= ~trig_tgl_r;
            end
        end
    end

    // Pixel FIFO doubles as the clock crossing for words
    pixel_fifo #(.WIDTH(24), .DEPTH(16)) u_fifo (
        .wr_clk(core_clk),
        .wr_rst_n(crst_n_r),
        .wr_data(stage_r),
        .wr_valid(stage_vld_r),
        .wr_ready(fifo_wready),
        .rd_clk(link_clk),
        .rd_rst_n(lrst_n_r),
        .rd_data(fifo_rd),
        .rd_valid(fifo_rvalid),
        .rd_ready(state_r == cl_pixel_pkg::L_ACT)
    );
    assign pop = fifo_rvalid & (state_r == cl_pixel_pkg::L_ACT);

    // Toggle and config levels into the link domain
    always_ff @(posedge link_clk or negedge lrst_n_r) begin
        if (!lrst_n_r) begin
            tgl_s1_r <= 1'h0;
            tgl_s2_r <= 1'h0;
            tgl_s3_r <= 1'h0;
            cfg_s1_r <= 4'h8; // Wait for a trigger until real levels arrive
            cfg_s2_r <= 4'h8; // Avoids a free-run frame right after reset
        end else begin
            tgl_s1_r <= trig_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
            cfg_s1_r <= {ext_mode, bin_mode, dual_tap};
            cfg_s2_r <= cfg_s1_r;
        end
    end
    assign trig_edge = tgl_s2_r ^ tgl_s3_r;
    // Free run starts at once; external control waits for a trigger
    assign start = (state_r == cl_pixel_pkg::L_IDLE) & (~cfg_s2_r[3] | trig_pend_r);

    // Pending trigger; a new edge wins over the clear
    always_ff @(posedge link_clk or negedge lrst_n_r) begin
        if (!lrst_n_r) begin
            trig_pend_r <= 1'h0;
        end else begin
            trig_pend_r <= trig_edge | (trig_pend_r & ~start);
        end
    end

    assign line_len = h_lead_r + h_act_r + `CL_HBLANK;

    // Frame and line timing generator
    always_ff @(posedge link_clk or negedge lrst_n_r) begin
        if (!lrst_n_r) begin
            state_r <= cl_pixel_pkg::L_IDLE;
            pix_cnt_r <= 11'h000;
            line_cnt_r <= 9'h000;
            h_lead_r <= `CL_HLEAD_S_B1;
            h_act_r <= `CL_HACT_S_B1;
            v_lead_r <= `CL_VLEAD_B1;
            v_act_r <= `CL_VACT_B1;
            frm_dual_r <= 1'h0;
            frm_bin_r <= cl_pixel_pkg::BIN_NONE;
        end else begin
            case (state_r)
                cl_pixel_pkg::L_IDLE: begin
                    // Mode is frozen for the whole frame
                    if (start) begin
                        frm_dual_r <= cfg_s2_r[0];
                        frm_bin_r <= cl_pixel_pkg::bin_mode_t'(cfg_s2_r[2:1]);
                        h_lead_r <= h_lead_f(cfg_s2_r[0], cl_pixel_pkg::bin_mode_t'(cfg_s2_r[2:1]));
                        h_act_r <= h_act_f(cfg_s2_r[0], cl_pixel_pkg::bin_mode_t'(cfg_s2_r[2:1]));
                        {v_lead_r, v_act_r} <= v_cnt_f(cl_pixel_pkg::bin_mode_t'(cfg_s2_r[2:1]));
                        pix_cnt_r <= 11'h000;
                        line_cnt_r <= 9'h000;
                        state_r <= cl_pixel_pkg::L_LEAD;
                    end
                end
                cl_pixel_pkg::L_LEAD: begin
                    // Lead line periods with FVAL high and LVAL low
                    if (pix_cnt_r == line_len - 11'h001) begin
                        pix_cnt_r <= 11'h000;
                        if (line_cnt_r == v_lead_r - 9'h001) begin
                            line_cnt_r <= 9'h000;
                            state_r <= cl_pixel_pkg::L_HLEAD;
                        end else begin
                            line_cnt_r <= line_cnt_r + 9'h001;
                        end
                    end else begin
                        pix_cnt_r <= pix_cnt_r + 11'h001;
                    end
                end
                cl_pixel_pkg::L_HLEAD: begin
                    // LVAL lead-in before the first valid pixel
                    if (pix_cnt_r == h_lead_r - 11'h001) begin
                        pix_cnt_r <= 11'h000;
                        state_r <= cl_pixel_pkg::L_ACT;
                    end else begin
                        pix_cnt_r <= pix_cnt_r + 11'h001;
                    end
                end
                cl_pixel_pkg::L_ACT: begin
                    // Counts taken pixels; an empty FIFO stretches the line
                    if (pop) begin
                        if (pix_cnt_r == h_act_r - 11'h001) begin
                            pix_cnt_r <= 11'h000;
                            state_r <= cl_pixel_pkg::L_HBLK;
                        end else begin
                            pix_cnt_r <= pix_cnt_r + 11'h001;
                        end
                    end
                end
                cl_pixel_pkg::L_HBLK: begin
                    // Horizontal blanking, then next line or end of frame
                    if (pix_cnt_r == `CL_HBLANK - 11'h001) begin
                        pix_cnt_r <= 11'h000;
                        if (line_cnt_r == v_act_r - 9'h001) begin
                            line_cnt_r <= 9'h000;
                            state_r <= cl_pixel_pkg::L_VBLK;
                        end else begin
                            line_cnt_r <= line_cnt_r + 9'h001;
                            state_r <= cl_pixel_pkg::L_HLEAD;
                        end
                    end else begin
                        pix_cnt_r <= pix_cnt_r + 11'h001;
                    end
                end
                cl_pixel_pkg::L_VBLK: begin
                    // Vertical blanking with FVAL low
                    if (pix_cnt_r == `CL_VBLANK - 11'h001) begin
                        pix_cnt_r <= 11'h000;
                        state_r <= cl_pixel_pkg::L_IDLE;
                    end else begin
                        pix_cnt_r <= pix_cnt_r + 11'h001;
                    end
                end
                default: begin
                    state_r <= cl_pixel_pkg::L_IDLE;
                end
            endcase
        end
    end

    assign lval_nxt = (state_r == cl_pixel_pkg::L_HLEAD) | (state_r == cl_pixel_pkg::L_ACT);
    assign fval_nxt = lval_nxt | (state_r == cl_pixel_pkg::L_LEAD) |
                      (state_r == cl_pixel_pkg::L_HBLK);

    // Serializer lanes registered; pixel lanes are zero outside DVAL
    always_ff @(posedge link_clk or negedge lrst_n_r) begin
        if (!lrst_n_r) begin
            tx <= 28'h0000000;
        end else begin
            // Taps, qualifiers and spare lane in one mapping
            tx <= tx_map_f(pop ? fifo_rd : '0, lval_nxt, fval_nxt, pop);
        end
    end

    spare_low_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r) !tx[23])
        else $error("spare lane driven high");
    dval_in_lval_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r) tx[26] |-> tx[24])
        else $error("DVAL outside LVAL");
    lval_in_fval_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r) tx[24] |-> tx[25])
        else $error("LVAL outside FVAL");
    lead_in_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r) $rose(tx[24]) |-> !tx[26] [*8])
        else $error("DVAL too soon after LVAL");
    lane_data_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        pop |=> tx[26] && tx[4:0] == $past(fifo_rd.tap_a[4:0]) && tx[27] == $past(fifo_rd.tap_a[6])
        && tx[12] == $past(fifo_rd.tap_a[11]) && tx[15] == $past(fifo_rd.tap_b[0]))
        else $error("pixel lanes mismatch");
    single_tap_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        (tx[26] && !frm_dual_r) |-> tx[22:13] == 10'h000 && tx[11:10] == 2'h0)
        else $error("second tap active in single-tap readout");
    line_bound_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        (state_r == cl_pixel_pkg::L_HBLK) |-> line_cnt_r < v_act_r)
        else $error("too many active lines");
    normal_size_a:
    assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        (state_r == cl_pixel_pkg::L_LEAD && frm_bin_r == cl_pixel_pkg::BIN_NONE && !frm_dual_r)
        |-> h_act_r == 11'h280 && v_act_r == 9'h1E0)
        else $error("normal readout size wrong");
    unity_gain_a:
    assert property (@(posedge core_clk) disable iff (!crst_n_r)
        (accept && gain_step == 4'h0) |=> stage_r.tap_a == $past(pix_in.tap_a))
        else $error("unity gain alters pixel");
    trig_event_a:
    assert property (@(posedge core_clk) disable iff (!crst_n_r)
        (trig_act && !trig_prev_r) |=> trig_tgl_r != $past(trig_tgl_r))
        else $error("trigger edge lost");

    dual_frame_c: cover property (@(posedge link_clk) disable iff (!lrst_n_r)
        start && cfg_s2_r[0]);
    ext_start_c: cover property (@(posedge link_clk) disable iff (!lrst_n_r)
        start && cfg_s2_r[3]);
    fifo_full_c: cover property (@(posedge core_clk) disable iff (!crst_n_r)
        stage_vld_r && !fifo_wready);
    line_stall_c: cover property (@(posedge link_clk) disable iff (!lrst_n_r)
        state_r == cl_pixel_pkg::L_ACT && !fifo_rvalid);
endmodule : camera_link_pixel_output

/* test/grabber_model.sv */
// Receiving frame grabber: measures line timing and captures the first pixel word
`timescale 1ns/1ps
module grabber_model (
    // Link side
    input wire logic link_clk,
    input wire logic [27:0] tx,
    // Measurements
    output int lead,
    output int act,
    output int lines,
    output logic [27:0] first,
    output int frames
);
    logic lv_r = 1'b0; // LVAL one clock back
    logic fv_r = 1'b0; // FVAL one clock back
    initial begin
        lead = 0;
        act = 0;
        lines = 0;
        first = '0;
        frames = 0;
    end
    // Lead-in clocks before the first valid pixel, then valid pixels only
    always @(posedge link_clk) begin
        // Frames counted at each FVAL rise
        if (tx[25] && !fv_r) frames <= frames + 1;
        fv_r <= tx[25];
        if (tx[24] && !lv_r) begin
            lead <= tx[26] ? 0 : 1;
            act <= tx[26] ? 1 : 0;
        end else if (tx[24] && !tx[26] && act == 0) begin
            lead <= lead + 1;
        end else if (tx[26]) begin
            act <= act + 1;
        end
        // Pixel lanes are only meaningful while DVAL is high
        if (tx[26] && (act == 0 || !lv_r)) first <= tx;
        if (!tx[24] && lv_r) lines <= lines + 1;
        lv_r <= tx[24];
    end
endmodule : grabber_model

/* test/camera_link_pixel_output_test.sv */
// Self-checking bench for the pixel output formatter
`timescale 1ns/1ps
module camera_link_pixel_output_test;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic resetn = 1'b0;
    cl_pixel_pkg::pixel_pair_t pix_in = '0;
    logic pix_valid = 1'b0;
    logic pix_ready;
    logic trig_pin = 1'b0;
    logic dual_tap = 1'b1;
    logic trig_pol_pos = 1'b1;
    logic [27:0] tx;
    int lead, act, lines, frames, word_n = 0, fails = 0, compares = 0;
    logic [27:0] first;
    always #2.5 core_clk = ~core_clk;
    // Phase offset keeps four of every five link edges away from the core edges; every fifth lands on one
    initial #7 forever #32 link_clk = ~link_clk;
    camera_link_pixel_output uut (.core_clk(core_clk), .resetn(resetn), .link_clk(link_clk),
        .pix_in(pix_in), .pix_valid(pix_valid), .pix_ready(pix_ready), .dual_tap(dual_tap),
        .bin_mode(cl_pixel_pkg::BIN_8X8), .gain_step(4'h0), .ext_mode(1'b1),
        .trig_pol_pos(trig_pol_pos), .trig_src_cc(1'b0), .trig_pin(trig_pin), .cc1_pin(1'b0),
        .tx(tx));
    grabber_model grabber (.link_clk(link_clk), .tx(tx), .lead(lead), .act(act),
        .lines(lines), .first(first), .frames(frames));
    // Lane map of both taps with LVAL, FVAL and DVAL high
    function automatic logic [27:0] lanes(input logic [11:0] a, input logic [11:0] b);
        logic [27:0] t;
        t = 28'h7000000;
        t[4:0] = a[4:0];
        t[6] = a[5];
        t[27] = a[6];
        t[5] = a[7];
        t[9:7] = a[10:8];
        t[12] = a[11];
        t[15] = b[0];
        t[22:18] = b[5:1];
        t[16] = b[6];
        t[17] = b[7];
        t[14:13] = b[9:8];
        t[11:10] = b[11:10];
        return t;
    endfunction : lanes
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // Pixel source; word n carries a ramp on each tap, taken when ready was seen high
    task automatic feed();
        logic took;
        took = 1'b0;
        repeat (30000) begin
            @(negedge core_clk);
            if (took) word_n++;
            pix_in.tap_a = 12'hA5C - 12'(word_n);
            pix_in.tap_b = 12'h3C9 + 12'(word_n);
            pix_valid = 1'b1;
            took = pix_ready;
        end
    endtask : feed
    // External control mode: no frame may start before the trigger
    task automatic no_frame_untriggered();
        int f0;
        f0 = frames;
        repeat (60) @(negedge link_clk);
        check(32'(frames), 32'(f0));
    endtask : no_frame_untriggered
    // One triggered line: lead-in, dual-tap active count and lane map of the first word
    task automatic first_line();
        int i;
        @(negedge core_clk);
        trig_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        trig_pin = 1'b0;
        for (i = 0; i < 2000 && lines < 1; i++) @(negedge link_clk);
        if (lines < 1) begin
            fails++;
            return;
        end
        check(32'(lead), 32'd46);
        check(32'(act), 32'd40);
        check(32'(first), 32'(lanes(12'hA5C, 12'h3C9)));
        check(32'(tx[25:23]), 32'h4);
    endtask : first_line
    // Mid-run reset, then one single-tap line started by an active-low trigger
    task automatic single_tap_line();
        int i, n0, l0;
        @(negedge core_clk);
        resetn = 1'b0;
        dual_tap = 1'b0;
        trig_pol_pos = 1'b0;
        trig_pin = 1'b1;
        repeat (4) @(negedge link_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        n0 = word_n;
        no_frame_untriggered();
        l0 = lines;
        @(negedge core_clk);
        trig_pin = 1'b0;
        repeat (4) @(negedge core_clk);
        trig_pin = 1'b1;
        for (i = 0; i < 2000 && lines <= l0; i++) @(negedge link_clk);
        if (lines <= l0) begin
            fails++;
            return;
        end
        check(32'(lead), 32'd48);
        check(32'(act), 32'd80);
        check(32'(first), 32'(lanes(12'hA5C - 12'(n0), 12'h000)));
    endtask : single_tap_line
    initial begin
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        fork
            feed();
        join_none
        no_frame_untriggered();
        first_line();
        single_tap_line();
        print_verdict();
    end
endmodule : camera_link_pixel_output_test
